// ===== shared/sfg_pkg.sv
package sfg_pkg;

  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_STATUS_READ   = 8'h05;
  localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE_A = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE_B = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hc7;
  localparam logic [7:0] OP_SECURITY_READ = 8'h2b;
  localparam logic [7:0] OP_SECURITY_WRITE = 8'h2f;
  localparam logic [7:0] OP_ENTER_SECURED = 8'hb1;
  localparam logic [7:0] OP_EXIT_SECURED  = 8'hc1;
  localparam logic [7:0] OP_DEEP_SLEEP    = 8'hb9;
  localparam logic [7:0] OP_WAKE_FROM_SLEEP = 8'hab;

  // Frame lengths in whole bytes
  localparam logic [2:0] LEN_OPCODE_ONLY = 3'h1;
  localparam logic [2:0] LEN_STATUS_WRITE = 3'h2;
  localparam logic [2:0] LEN_ADDRESSED   = 3'h4;
  localparam logic [2:0] LEN_PROGRAM_MIN = 3'h5;
  localparam logic [2:0] LEN_SATURATE    = 3'h7;

  // Status byte layout
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_WEL_BIT   = 1;
  localparam int ST_CODE_LSB  = 2;
  localparam int ST_LOCK_BIT  = 7;
  localparam logic [3:0] CODE_RESET = 4'h0;

  // Security byte layout
  localparam int SEC_FACTORY_BIT  = 0;
  localparam int SEC_CUSTOMER_BIT = 1;

  // Block protection geometry
  localparam logic [7:0] NUM_BLOCKS   = 8'h80;
  localparam int         BLOCK_LSB    = 16;
  localparam logic [3:0] CODE_TOP_MAX = 4'h6;
  localparam logic [3:0] CODE_BOT_MIN = 4'h9;
  localparam logic [3:0] CODE_BOT_MAX = 4'he;

  // One-time area offsets
  localparam logic [5:0] OTP_SERIAL_LAST = 6'h0f;
  localparam logic [5:0] OTP_LAST        = 6'h3f;

  // Array operation kinds
  localparam logic [1:0] AOP_PROGRAM = 2'h0;
  localparam logic [1:0] AOP_SECTOR  = 2'h1;
  localparam logic [1:0] AOP_BLOCK   = 2'h2;
  localparam logic [1:0] AOP_CHIP    = 2'h3;

  localparam int BUSY_CYCLES_DEFAULT = 16;

  typedef enum logic [1:0] {
    MODE_STANDBY,
    MODE_BUSY,
    MODE_SLEEP
  } sfg_mode_e;

endpackage

// ===== rtl/sfg_write_guard.sv
//////////////////////////////////////////////////////////////////////////////////////////////////
module sfg_write_guard
  import sfg_pkg::*;
#(
  parameter int BUSY_CYCLES = sfg_pkg::BUSY_CYCLES_DEFAULT
) (
  input  wire logic                i_clock,
  input  wire logic                i_reset_n,
  input  wire logic                i_sclk,
  input  wire logic                i_cs_n,
  input  wire logic                i_si,
  input  wire logic                i_hold_n,
  input  wire logic                i_wp_n,
  input  wire logic                i_factory_lock,
  output logic                     o_so,
  output logic                     o_so_oe,
  output logic                     o_hold,
  output logic [7:0]               o_status,
  output logic [7:0]               o_security,
  output logic                     o_write_enable_latch,
  output logic                     o_deep_sleep,
  output logic                     o_secured_mode,
  output logic                     o_busy,
  output logic                     o_array_req,
  output logic [1:0]               o_array_op,
  output logic [23:0]              o_array_addr,
  output logic                     o_otp_req,
  output logic [5:0]               o_otp_offset,
  output logic                     o_otp_customer_area
);
  import sfg_pkg::*;

  initial begin
    if (BUSY_CYCLES < 1 || BUSY_CYCLES > 65535) begin
      $error("BUSY_CYCLES must lie in 1..65535");
    end
  end

  localparam logic [15:0] BUSY_LOAD = 16'(BUSY_CYCLES);

  // True when the code covers the given block
  function automatic logic is_protected(input logic [3:0] code, input logic [6:0] block);
    logic [7:0] blk;
    logic [7:0] edge_blk;
    blk      = {1'b0, block};
    edge_blk = 8'h00;
    is_protected = 1'b1;
    if (code == 4'h0) begin
      is_protected = 1'b0;
    end else if (code <= CODE_TOP_MAX) begin
      edge_blk     = NUM_BLOCKS - (8'h01 << code);
      is_protected = (blk >= edge_blk);
    end else if (code >= CODE_BOT_MIN && code <= CODE_BOT_MAX) begin
      edge_blk     = NUM_BLOCKS - (NUM_BLOCKS >> (code - 4'h8));
      is_protected = (blk < edge_blk);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Link side, clocked by the serial clock

  typedef struct packed {
    logic [7:0]  shift;
    logic [2:0]  bit_idx;
    logic [2:0]  bytes;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic        reading;
  } sfg_link_s;

  sfg_link_s link_q;
  sfg_link_s link_d;
  sfg_link_s link_base;
  logic      frame_start_q;
  logic      so_q;
  logic [7:0] status_word;
  logic [7:0] security_word;

  // Set while deselected so the next frame starts clean but the finished
  // frame's fields stay readable after chip select rises.
  always_ff @(posedge i_sclk or posedge i_cs_n or negedge rst_n) begin
    if (!rst_n) begin
      frame_start_q <= 1'b1;
    end else if (i_cs_n) begin
      frame_start_q <= 1'b1;
    end else if (i_hold_n) begin
      frame_start_q <= 1'b0;
    end
  end

  always_comb begin
    link_base = frame_start_q ? '0 : link_q;
    link_d    = link_base;
    if (!i_hold_n) begin
      link_d = link_q;
    end else begin
      link_d.shift   = {link_base.shift[6:0], i_si};
      link_d.bit_idx = link_base.bit_idx + 3'h1;
      if (link_base.bit_idx == 3'h7) begin
        if (link_base.bytes != LEN_SATURATE) begin
          link_d.bytes = link_base.bytes + 3'h1;
        end
        unique case (link_base.bytes)
          3'h0: begin
            link_d.opcode  = link_d.shift;
            link_d.reading = (link_d.shift == OP_STATUS_READ) ||
                             (link_d.shift == OP_SECURITY_READ);
          end
          3'h1: link_d.addr[23:16] = link_d.shift;
          3'h2: link_d.addr[15:8]  = link_d.shift;
          3'h3: link_d.addr[7:0]   = link_d.shift;
          default: link_d.addr     = link_base.addr;
        endcase
      end
    end
  end

  always_ff @(posedge i_sclk or negedge rst_n) begin
    if (!rst_n) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  // Read words change only between frames, apart from the busy bit, which can fall while shifted out
  always_ff @(negedge i_sclk or negedge rst_n) begin
    if (!rst_n) begin
      so_q <= 1'b0;
    end else if (i_hold_n && link_q.reading) begin
      so_q <= (link_q.opcode == OP_SECURITY_READ) ? security_word[~link_q.bit_idx]
                                                  : status_word[~link_q.bit_idx];
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Control side, clocked by the system clock

  localparam int SY_CS    = 0;
  localparam int SY_SCLK  = 1;
  localparam int SY_HOLD  = 2;
  localparam int SY_WP    = 3;
  localparam int SY_READ  = 4;
  localparam int SY_STRAP = 5;

  typedef struct packed {
    logic [5:0]  meta;
    logic [5:0]  sync;
    logic        cs_prev;
    logic [2:0]  strap_age;
    logic        factory;
    logic        customer;
    logic [3:0]  code;
    logic        status_lock;
    logic        write_enable_latch;
    logic        secured;
    logic        asleep;
    sfg_mode_e   mode;
    logic        busy;
    logic [15:0] busy_cnt;
    logic        hold;
    logic        oe;
    logic        array_req;
    logic [1:0]  array_op;
    logic [23:0] array_addr;
    logic        otp_req;
    logic [5:0]  otp_offset;
    logic        otp_customer;
  } sfg_sys_s;

  sfg_sys_s sys_q;
  sfg_sys_s sys_d;

  logic [7:0] op;
  logic [2:0] len;
  logic       frame_end;
  logic       whole;
  logic       target_hit;
  logic       any_lock;
  logic       write_ok;

  assign op         = link_q.opcode;
  assign len        = link_q.bytes;
  assign frame_end  = sys_q.sync[SY_CS] && !sys_q.cs_prev;
  assign whole      = (link_q.bit_idx == 3'h0);
  assign target_hit = is_protected(sys_q.code, link_q.addr[BLOCK_LSB +: 7]);
  assign any_lock   = sys_q.factory || sys_q.customer;
  assign write_ok   = sys_q.write_enable_latch && (sys_q.mode == MODE_STANDBY);

  always_comb begin
    sys_d           = sys_q;
    sys_d.meta      = {i_factory_lock, link_q.reading, i_wp_n, i_hold_n, i_sclk, i_cs_n};
    sys_d.sync      = sys_q.meta;
    sys_d.cs_prev   = sys_q.sync[SY_CS];
    sys_d.array_req = 1'b0;
    sys_d.otp_req   = 1'b0;

    // Strap is caught once, three cycles after release, when the sync holds the real pin
    if (!sys_q.strap_age[2]) begin
      sys_d.strap_age = {sys_q.strap_age[1:0], 1'b1};
      sys_d.factory   = sys_q.strap_age[1] ? sys_q.sync[SY_STRAP] : sys_q.factory;
    end

    // Hold only moves while the serial clock is low, except that deselect clears it whatever the clock level
    if (sys_q.sync[SY_CS]) begin
      sys_d.hold = 1'b0;
    end else if (!sys_q.sync[SY_SCLK]) begin
      if (!sys_q.hold && !sys_q.sync[SY_HOLD]) begin
        sys_d.hold = 1'b1;
      end else if (sys_q.hold && sys_q.sync[SY_HOLD]) begin
        sys_d.hold = 1'b0;
      end
    end
    sys_d.oe = sys_q.sync[SY_READ] && !sys_q.sync[SY_CS] && !sys_d.hold;

    // Hold never touches the running operation
    unique case (sys_q.mode)
      MODE_BUSY: begin
        if (sys_q.busy_cnt == 16'h0001) begin
          sys_d.mode = sys_q.asleep ? MODE_SLEEP : MODE_STANDBY;
        end
        sys_d.busy_cnt = sys_q.busy_cnt - 16'h0001;
      end
      MODE_SLEEP: begin
        if (frame_end && whole && len == LEN_OPCODE_ONLY && op == OP_WAKE_FROM_SLEEP) begin
          sys_d.mode   = MODE_STANDBY;
          sys_d.asleep = 1'b0;
        end
      end
      MODE_STANDBY: begin
        if (frame_end && whole) begin
          unique case (op)
            OP_WRITE_ENABLE: begin
              if (len == LEN_OPCODE_ONLY) begin
                sys_d.write_enable_latch = 1'b1;
              end
            end
            OP_WRITE_DISABLE: begin
              if (len == LEN_OPCODE_ONLY) begin
                sys_d.write_enable_latch = 1'b0;
              end
            end
            OP_STATUS_WRITE: begin
              if (len == LEN_STATUS_WRITE && write_ok &&
                  !(sys_q.status_lock && !sys_q.sync[SY_WP])) begin
                sys_d.code        = link_q.addr[16 + ST_CODE_LSB +: 4];
                sys_d.status_lock = link_q.addr[16 + ST_LOCK_BIT];
                sys_d.write_enable_latch         = 1'b0;
                sys_d.mode        = MODE_BUSY;
                sys_d.busy_cnt    = BUSY_LOAD;
              end
            end
            OP_PAGE_PROGRAM: begin
              if (len >= LEN_PROGRAM_MIN && write_ok) begin
                if (sys_q.secured) begin
                  if (!any_lock && link_q.addr[23:6] == 18'h00000) begin
                    sys_d.otp_req      = 1'b1;
                    sys_d.otp_offset   = link_q.addr[5:0];
                    sys_d.otp_customer = link_q.addr[5:0] > OTP_SERIAL_LAST;
                    sys_d.write_enable_latch          = 1'b0;
                    sys_d.mode         = MODE_BUSY;
                    sys_d.busy_cnt     = BUSY_LOAD;
                  end
                end else if (!target_hit) begin
                  sys_d.array_req  = 1'b1;
                  sys_d.array_op   = AOP_PROGRAM;
                  sys_d.array_addr = link_q.addr;
                  sys_d.write_enable_latch        = 1'b0;
                  sys_d.mode       = MODE_BUSY;
                  sys_d.busy_cnt   = BUSY_LOAD;
                end
              end
            end
            OP_SECTOR_ERASE, OP_BLOCK_ERASE_A, OP_BLOCK_ERASE_B: begin
              if (len == LEN_ADDRESSED && write_ok && !sys_q.secured &&
                  !target_hit) begin
                sys_d.array_req  = 1'b1;
                sys_d.array_op   = (op == OP_SECTOR_ERASE) ? AOP_SECTOR : AOP_BLOCK;
                sys_d.array_addr = link_q.addr;
                sys_d.write_enable_latch        = 1'b0;
                sys_d.mode       = MODE_BUSY;
                sys_d.busy_cnt   = BUSY_LOAD;
              end
            end
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
              if (len == LEN_OPCODE_ONLY && write_ok && !sys_q.secured &&
                  sys_q.code == CODE_RESET) begin
                sys_d.array_req  = 1'b1;
                sys_d.array_op   = AOP_CHIP;
                sys_d.array_addr = 24'h000000;
                sys_d.write_enable_latch        = 1'b0;
                sys_d.mode       = MODE_BUSY;
                sys_d.busy_cnt   = BUSY_LOAD;
              end
            end
            OP_SECURITY_WRITE: begin
              if (len == LEN_OPCODE_ONLY && !any_lock) begin
                sys_d.customer = 1'b1;
              end
            end
            OP_ENTER_SECURED: begin
              if (len == LEN_OPCODE_ONLY) begin
                sys_d.secured = 1'b1;
              end
            end
            OP_EXIT_SECURED: begin
              if (len == LEN_OPCODE_ONLY) begin
                sys_d.secured = 1'b0;
              end
            end
            OP_DEEP_SLEEP: begin
              if (len == LEN_OPCODE_ONLY) begin
                sys_d.asleep = 1'b1;
                sys_d.mode   = MODE_SLEEP;
              end
            end
            default: sys_d.mode = MODE_STANDBY;
          endcase
        end
      end
      default: sys_d.mode = MODE_STANDBY;
    endcase
    sys_d.busy = (sys_d.mode == MODE_BUSY);
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      sys_q      <= '0;
      sys_q.mode <= MODE_STANDBY;
      sys_q.meta <= 6'h3f;
      sys_q.sync <= 6'h3f;
      sys_q.cs_prev <= 1'b1;
    end else begin
      sys_q <= sys_d;
    end
  end

  always_comb begin
    status_word                = 8'h00;
    status_word[ST_BUSY_BIT]   = sys_q.busy;
    status_word[ST_WEL_BIT]    = sys_q.write_enable_latch;
    status_word[ST_CODE_LSB +: 4] = sys_q.code;
    status_word[ST_LOCK_BIT]   = sys_q.status_lock;
    security_word                   = 8'h00;
    security_word[SEC_FACTORY_BIT]  = sys_q.factory;
    security_word[SEC_CUSTOMER_BIT] = sys_q.customer;
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_so                 = so_q;
  assign o_so_oe              = sys_q.oe;
  assign o_hold               = sys_q.hold;
  assign o_write_enable_latch = sys_q.write_enable_latch;
  assign o_deep_sleep         = sys_q.asleep;
  assign o_secured_mode       = sys_q.secured;
  assign o_busy               = sys_q.busy;
  assign o_array_req          = sys_q.array_req;
  assign o_array_op           = sys_q.array_op;
  assign o_array_addr         = sys_q.array_addr;
  assign o_otp_req            = sys_q.otp_req;
  assign o_otp_offset         = sys_q.otp_offset;
  assign o_otp_customer_area  = sys_q.otp_customer;
  assign o_status             = {sys_q.status_lock, 1'b0, sys_q.code, sys_q.write_enable_latch, sys_q.busy};
  assign o_security           = {6'h00, sys_q.customer, sys_q.factory};

endmodule

// ===== test/sfg_chk.sv
module sfg_chk
  import sfg_pkg::*;
#(
  parameter int BUSY_CYCLES = BUSY_CYCLES_DEFAULT
) (
  input wire logic       i_clock,
  input wire logic       i_reset_n,
  input wire logic       i_wp_n,
  input wire logic       o_so_oe,
  input wire logic       o_hold,
  input wire logic [7:0] o_status,
  input wire logic [7:0] o_security,
  input wire logic       o_write_enable_latch,
  input wire logic       o_deep_sleep,
  input wire logic       o_secured_mode,
  input wire logic       o_array_req,
  input wire logic       o_otp_req,
  input wire logic [5:0] o_otp_offset,
  input wire logic       o_otp_customer_area
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);
  // Output enable drops in the same cycle as hold rises; only a hold held three cycles is judged
  sequence s_hold_settled; o_hold [*3]; endsequence
  // Pin passes two flops first, so the lock is judged once it has landed
  sequence s_wp_locked; (!i_wp_n && o_status[ST_LOCK_BIT]) [*4]; endsequence
  property p_req_single; o_array_req |=> !o_array_req; endproperty
  a_req_single: assert property (p_req_single) else $error("req too long");
  property p_req_latch; o_array_req |-> $past(o_write_enable_latch) || $past(o_write_enable_latch, 2); endproperty
  a_req_latch: assert property (p_req_latch) else $error("req without latch");
  property p_asleep; o_deep_sleep [*2] |-> $stable(o_write_enable_latch) && !o_array_req && !o_otp_req; endproperty
  a_asleep: assert property (p_asleep) else $error("change in sleep");
  property p_full; o_array_req |-> !(o_status[5:2] inside {4'h7, 4'h8, 4'hf}); endproperty
  a_full: assert property (p_full) else $error("req under full guard");
  property p_wp_hold; s_wp_locked |=> $stable(o_status[7:2]); endproperty
  a_wp_hold: assert property (p_wp_hold) else $error("guarded bits moved");
  property p_sticky; o_security[SEC_CUSTOMER_BIT] |=> o_security[SEC_CUSTOMER_BIT]; endproperty
  a_sticky: assert property (p_sticky) else $error("lock cleared");
  property p_otp_locked; o_otp_req |-> o_security[1:0] == 2'h0; endproperty
  a_otp_locked: assert property (p_otp_locked) else $error("locked area written");
  property p_secured; o_secured_mode |-> !o_array_req; endproperty
  a_secured: assert property (p_secured) else $error("array reached");
  property p_area; o_otp_req |-> o_otp_customer_area == (o_otp_offset > OTP_SERIAL_LAST); endproperty
  a_area: assert property (p_area) else $error("area flag wrong");
  property p_hold_quiet; s_hold_settled |-> !o_so_oe; endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("output driven in hold");
endmodule

bind sfg_write_guard sfg_chk #(.BUSY_CYCLES(BUSY_CYCLES)) i_chk (
  .i_clock, .i_reset_n, .i_wp_n, .o_so_oe, .o_hold, .o_status, .o_security,
  .o_write_enable_latch, .o_deep_sleep, .o_secured_mode, .o_array_req, .o_otp_req,
  .o_otp_offset, .o_otp_customer_area
);

// ===== test/sfg_host_model.sv
module sfg_host_model (
  input  wire logic i_so,
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si,
  output logic o_hold_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // Clock idles low between frames, mode 0
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    o_hold_n = 1'b1;
  end
  // Frame bits are left-aligned; n not a multiple of 8 makes a torn frame
  task automatic send(input logic [63:0] bits, input int n, input int hold_at);
    o_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_si = bits[63-i];
      #24 o_sclk = 1'b1;
      if (i == hold_at) begin
        // Hold falls just after the rise so that bit is still taken
        #5 o_hold_n = 1'b0;
        #195 o_sclk = 1'b0;
        #200 o_si = ~o_si;
        #24 o_sclk = 1'b1;
        #24 o_sclk = 1'b0;
        #100 o_hold_n = 1'b1;
        #100;
      end else
        #24 o_sclk = 1'b0;
    end
    #24 o_cs_n = 1'b1;
    o_si = ~o_si;
    #200;
  endtask
  // Opcode byte, then one byte read back, each bit taken on the clock rise
  task automatic read(input logic [7:0] cmd, output logic [7:0] data);
    o_cs_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      o_si = (i < 8) ? cmd[7-i] : 1'b0;
      #24 o_sclk = 1'b1;
      if (i >= 8) data[15-i] = i_so;
      #24 o_sclk = 1'b0;
    end
    #24 o_cs_n = 1'b1;
    #200;
  endtask
endmodule

// ===== test/sfg_write_guard_test.sv
module sfg_write_guard_test
  import sfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wp_n = 1'b1;
  wire logic   sclk, cs_n, si, hold_n;
  localparam int BUSY_N = 4;
  logic        so, so_oe, hold, latch, asleep, secured, arr_req, otp_req, otp_cust, busy;
  logic [1:0]  arr_op;
  logic [7:0]  stat, secur;
  logic [23:0] arr_addr;
  logic [5:0]  otp_off;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          n_arr = 0;
  int          n_otp = 0;
  int          n_busy = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (arr_req === 1'b1) n_arr++;
  always @(posedge clk) if (otp_req === 1'b1) n_otp++;
  always @(posedge clk) if (busy === 1'b1) n_busy++;

  sfg_host_model i_host (.i_so(so), .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n));
  sfg_write_guard #(.BUSY_CYCLES(BUSY_N)) i_dut (
    .i_clock(clk), .i_reset_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
    .i_hold_n(hold_n), .i_wp_n(wp_n), .i_factory_lock(1'b0), .o_so(so), .o_so_oe(so_oe),
    .o_hold(hold), .o_status(stat), .o_security(secur), .o_write_enable_latch(latch),
    .o_deep_sleep(asleep), .o_secured_mode(secured), .o_busy(busy), .o_array_req(arr_req),
    .o_array_op(arr_op), .o_array_addr(arr_addr), .o_otp_req(otp_req), .o_otp_offset(otp_off),
    .o_otp_customer_area(otp_cust));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(logic [7:0] c, logic [23:0] a = 24'h0, int n = 8);
    i_host.send({c, a, 32'ha5000000}, n, -1);
  endtask
  function automatic int prot(int c, int b);
    if (c == 0) return 0;
    if (c <= 6) return b >= 128 - (2 << (c - 1));
    if (c == 7 || c == 8 || c == 15) return 1;
    return b < 128 - (128 >> (c - 8));
  endfunction

  task automatic t_latch;
    chk("standby", 0, {stat, latch, secur[0]});
    op(8'h02, 24'h000100, 40);
    chk("no latch", 0, n_arr);
    op(8'h06);
    op(8'h04);
    chk("cleared", 0, latch);
    op(8'h06);
    op(8'h20, 24'h0, 28);
    chk("torn", {32'h0, 1'b1}, {n_arr, latch});
    op(8'h02, 24'h123456, 40);
    chk("program", {32'h1, 24'h123456, 1'b0}, {n_arr, arr_addr, latch});
    chk("program kind", {AOP_PROGRAM, BUSY_N}, {arr_op, n_busy});
  endtask
  task automatic t_protect;
    int n;
    for (int c = 0; c < 16; c++) begin
      op(8'h06);
      op(8'h01, {2'h0, c[3:0], 18'h0}, 16);
      chk("code", c, stat[5:2]);
      for (int b = 0; b < 128; b += 127) begin
        op(8'h06);
        n = n_arr;
        op(b ? 8'hd8 : 8'h20, {1'b0, b[6:0], 16'h0}, 32);
        chk("erase", {n + 1 - prot(c, b), prot(c, b) == 1}, {n_arr, latch});
        if (prot(c, b) == 0) chk("erase kind", b ? AOP_BLOCK : AOP_SECTOR, arr_op);
      end
      op(8'h06);
      n = n_arr;
      op(c[0] ? 8'h60 : 8'hc7);
      chk("chip", n + (c == 0), n_arr);
      if (c == 0) chk("chip kind", AOP_CHIP, arr_op);
    end
    op(8'h06);
    op(8'h01, 24'h0, 16);
  endtask
  task automatic t_sleep;
    op(8'hb9);
    op(8'h06);
    chk("asleep", 2'h2, {asleep, latch});
    op(8'hab);
    chk("awake", 0, asleep);
  endtask
  task automatic t_otp;
    logic [5:0] offs [2] = '{6'h12, 6'h05};
    int         n0;
    logic [7:0] rd;
    n0 = n_arr;
    op(8'hb1);
    chk("secured", 1, secured);
    foreach (offs[k]) begin
      op(8'h06);
      op(8'h02, {18'h0, offs[k]}, 40);
      chk("otp", {n0, k + 1, offs[k], offs[k] > 6'h0f}, {n_arr, n_otp, otp_off, otp_cust});
    end
    op(8'hc1);
    op(8'h2f);
    chk("locked", 3'h2, {secured, secur[1:0]});
    i_host.read(8'h2b, rd);
    chk("security read", 8'h02, rd);
    op(8'hb1);
    op(8'h06);
    op(8'h02, 24'h000020, 40);
    chk("no rewrite", 2, n_otp);
    op(8'hc1);
  endtask
  task automatic t_hold;
    op(8'h04);
    fork
      i_host.send({8'h06, 56'h0}, 8, 3);
      begin
        wait (hold_n === 1'b0);
        #150 chk("deferred", 0, hold);
        #200 chk("in hold", 2'h2, {hold, so_oe});
      end
    join
    chk("resumed", 2'h1, {hold, latch});
  endtask
  task automatic t_wp;
    logic [7:0] rd;
    op(8'h01, 24'h840000, 16);
    @(posedge clk);
    #1 wp_n = 1'b0;
    op(8'h06);
    op(8'h01, 24'h0, 16);
    chk("guarded", {6'h21, 1'b1}, {stat[7:2], latch});
    i_host.read(8'h05, rd);
    chk("status read", 8'h86, rd);
    @(posedge clk);
    #1 wp_n = 1'b1;
    op(8'h01, 24'h0, 16);
    chk("unguarded", 0, stat[7:2]);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    t_latch;
    t_protect;
    t_sleep;
    t_otp;
    t_hold;
    t_wp;
    give_verdict;
  end
  initial begin
    #600000;
    fail_count++;
    give_verdict;
  end
endmodule
